// *** logic/fcs_map.svh ***
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// Widths of the parallel bus and of the operation counters.
`define FCS_ADDR_W 20
`define FCS_DATA_W 16
`define FCS_CNT_W 24

// Command codes decoded from the low data byte of a write cycle.
`define FCS_CMD_READ_ARRAY 8'hFF
`define FCS_CMD_READ_IDENT 8'h90
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_ERASE_SETUP 8'h20
`define FCS_CMD_CONFIRM 8'hD0
`define FCS_CMD_SUSPEND 8'hB0
`define FCS_CMD_PROG_SETUP 8'h40
`define FCS_CMD_PROG_ALT 8'h10
`define FCS_CMD_CFG_SETUP 8'h60
`define FCS_CMD_CFG_CONFIRM 8'h03

// Identifier read addresses.
`define FCS_ID_MFR_ADDR 20'h00000
`define FCS_ID_DEV_ADDR 20'h00001
`define FCS_ID_CFG_ADDR 20'h00005

// Field positions of operation_status.
`define FCS_ST_READY 7
`define FCS_ST_ESUSP 6
`define FCS_ST_EERR 5
`define FCS_ST_PERR 4
`define FCS_ST_VLOW 3
`define FCS_ST_PSUSP 2
`define FCS_ST_LOCK 1

// Reset values.
`define FCS_STATUS_RESET 8'h80
`define FCS_RCFG_RESET 16'h8000
`define FCS_RCFG_PAGE_BIT 15

// Default operation lengths in clock cycles.
`define FCS_ERASE_CYCLES 20000
`define FCS_PROG_CYCLES 100
`define FCS_SUSPEND_CYCLES 20

`endif

// *** logic/fcs_pkg.sv ***
`include "fcs_map.svh"

package fcs_pkg;
	// Command phase of the write decoder.
	typedef enum logic [3:0] {
		C_CMD = 4'h1,
		C_ERASE = 4'h2,
		C_PROG = 4'h4,
		C_CFG = 4'h8
	} fcs_phase_t;

	// Read mode of the data outputs.
	typedef enum logic [2:0] {
		RM_ARRAY = 3'h1,
		RM_IDENT = 3'h2,
		RM_STATUS = 3'h4
	} fcs_rmode_t;

	// Write state machine states.
	typedef enum logic [6:0] {
		W_IDLE = 7'h01,
		W_ERASE = 7'h02,
		W_ESW = 7'h04,
		W_ESUSP = 7'h08,
		W_PROG = 7'h10,
		W_PSW = 7'h20,
		W_PSUSP = 7'h40
	} fcs_mach_t;

	// Complete state of the sequencer.
	typedef struct packed {
		fcs_phase_t ph;
		fcs_rmode_t rm;
		fcs_mach_t mach;
		logic [7:0] stat;
		logic [`FCS_DATA_W-1:0] rcfg;
		logic [`FCS_CNT_W-1:0] ecnt;
		logic [`FCS_CNT_W-1:0] pcnt;
		logic [`FCS_CNT_W-1:0] scnt;
		logic chk;
		logic held;
		logic pend;
		logic ce_p;
		logic oe_p;
		logic av_p;
		logic bclk_p;
		logic wr_p;
		logic got;
		logic [`FCS_ADDR_W-1:0] al;
		logic [`FCS_DATA_W-1:0] dl;
		logic [7:0] snap;
		logic snap_ok;
		logic [`FCS_DATA_W-1:0] dq;
		logic dq_oe;
		logic [`FCS_ADDR_W-1:0] arr_addr;
		logic single;
		logic erase_go;
		logic prog_go;
		logic [`FCS_ADDR_W-1:0] op_addr;
		logic [`FCS_DATA_W-1:0] op_data;
	} fcs_state_t;
endpackage

// *** logic/fcs_sync.sv ***
`timescale 1ns/1ps

// Two-stage synchroniser for a group of pin inputs.
module fcs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk, // System clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic clk_en, // Freezes the stages while low.
	input wire logic [W-1:0] d, // Asynchronous inputs.
	output logic [W-1:0] q // Synchronised inputs.
);
	typedef struct packed {
		logic [W-1:0] m;
		logic [W-1:0] s;
	} fcs_sync_t;

	fcs_sync_t st_q;
	fcs_sync_t st_d;

	// The first stage feeds only the second stage.
	always_comb begin
		st_d.m = d;
		st_d.s = st_q.m;
	end

	// Both stages load together while enabled.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= {INIT, INIT};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s;
endmodule

// *** logic/fcs_sequencer.sv ***
`timescale 1ns/1ps
`include "fcs_map.svh"

// How it works
// - Leaving reset enters array read with page mode read configuration.
// - Array read command is ignored while erase or program runs unsuspended.
// - Array, identifier, status read and status clear ignore supply level.
// - Identifier mode returns maker code, device code, read configuration by address.
// - Identifier and status modes deliver single word reads only.
// - After status read command every read returns status until next command.
// - Status is captured at first of address valid, burst edge, select edges.
// - Error bits are set by the machine or a bad sequence and cleared only by status clear or reset.
// - Status clear, accepted only while the machine is idle, returns the device to array read.
// - Erase is setup then confirm with block address; block becomes all ones.
// - After erase or program sequences, reads return status.
// - Bit 7 reads one when ready, zero when busy.
// - Erase suspend halts and sets bits 7 and 6 until erase resume.
// - Bit 5 erase error, bit 4 program error, both mean bad sequence.
// - Bit 3 reports low supply, sampled only during an operation.
// - Program suspend halts and sets bits 7 and 2 until program resume.
// - Operation on locked block with protect pin low aborts and sets bit 1.
// - Program is setup with 40H or 10H then address and data write.
// - Erase suspended accepts only array read, program, suspend, status, resume.
// - Erase resume clears bits 6 and 7, continues erase, selects status read.
// - Erase resume waits until a program begun during suspend completes.
// - After reset status holds 80H and mode is array read.
// - Reset low during an operation aborts it.
// - Decode FFH, 90H, 70H, 50H, 20H, D0H and B0H commands.
module fcs_sequencer #(
	parameter int ERASE_CYCLES = `FCS_ERASE_CYCLES, // Erase run length.
	parameter int PROG_CYCLES = `FCS_PROG_CYCLES, // Program run length.
	parameter int SUSPEND_CYCLES = `FCS_SUSPEND_CYCLES, // Suspend latency.
	parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary value.
	parameter logic [15:0] DEV_CODE = 16'h5A3C // Arbitrary value.
) (
	input wire logic clk, // System clock, 125 MHz.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic chip_enable_n, // Chip enable pin.
	input wire logic write_enable_n, // Write enable pin.
	input wire logic output_enable_n, // Output enable pin.
	input wire logic address_valid_n, // Address valid pin.
	input wire logic burst_clk, // Burst clock pin, sampled.
	input wire logic write_protect_n, // Write protect pin.
	input wire logic vpp_ok, // Programming supply in range.
	input wire logic [`FCS_ADDR_W-1:0] addr, // Address pins.
	input wire logic [`FCS_DATA_W-1:0] dq_in, // Data pins, input side.
	input wire logic [`FCS_DATA_W-1:0] array_rdata, // Array word at array_addr.
	input wire logic block_locked, // Block at op_addr is locked.
	input wire logic array_fail, // Array engine reports failure.
	output logic [`FCS_DATA_W-1:0] dq_out, // Data pins, output side.
	output logic dq_oe, // Data pin drive enable.
	output logic [`FCS_ADDR_W-1:0] array_addr, // Array read address.
	output logic single_word, // No page or burst sequencing.
	output logic [`FCS_DATA_W-1:0] read_config, // Read configuration.
	output logic erase_go, // Start block erase at op_addr.
	output logic prog_go, // Start word program at op_addr.
	output logic [`FCS_ADDR_W-1:0] op_addr, // Target address.
	output logic [`FCS_DATA_W-1:0] op_data, // Program data.
	output logic [7:0] operation_status // Live status register.
);
	localparam logic [`FCS_CNT_W-1:0] ERASE_CNT = `FCS_CNT_W'(ERASE_CYCLES - 1);
	localparam logic [`FCS_CNT_W-1:0] PROG_CNT = `FCS_CNT_W'(PROG_CYCLES - 1);
	localparam logic [`FCS_CNT_W-1:0] SUSP_CNT = `FCS_CNT_W'(SUSPEND_CYCLES - 1);
	localparam int SYNC_W = 7 + `FCS_ADDR_W + `FCS_DATA_W;

	fcs_pkg::fcs_state_t q;
	fcs_pkg::fcs_state_t d;
	logic [SYNC_W-1:0] sync_out;
	logic s_ce;
	logic s_we;
	logic s_oe;
	logic s_av;
	logic s_bclk;
	logic s_wp;
	logic s_vpp;
	logic [`FCS_ADDR_W-1:0] s_addr;
	logic [`FCS_DATA_W-1:0] s_dq;
	logic wr;
	logic wr_end;
	logic rd;
	logic evt;
	logic busy;
	logic prog_end;
	logic [7:0] c;
	logic [7:0] set_v;
	logic [7:0] clr_v;

	////////////////////////////////////////////////////////////////////////
	// All pin inputs pass two flip-flops before any logic sees them.
	fcs_sync #(
		.W(SYNC_W),
		.INIT({{7{1'b1}}, {(`FCS_ADDR_W + `FCS_DATA_W){1'b0}}})
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.d({chip_enable_n, write_enable_n, output_enable_n, address_valid_n,
			burst_clk, write_protect_n, vpp_ok, addr, dq_in}),
		.q(sync_out)
	);

	// Unpack the synchronised pins and derive the bus cycle terms.
	assign {s_ce, s_we, s_oe, s_av, s_bclk, s_wp, s_vpp, s_addr, s_dq} = sync_out;
	assign wr = !s_ce && !s_we && s_oe;
	assign wr_end = q.wr_p && !wr;
	assign rd = !s_ce && !s_oe && s_we;
	assign c = q.dl[7:0];
	assign evt = (s_av && !q.av_p) || (!s_ce && q.ce_p) || (!s_oe && q.oe_p) ||
		(!q.rcfg[`FCS_RCFG_PAGE_BIT] && !s_av && s_bclk && !q.bclk_p);

	////////////////////////////////////////////////////////////////////////
	// Next state: write capture, machine progress, command decode, reads.
	always_comb begin
		d = q;
		set_v = 8'h00;
		clr_v = 8'h00;
		prog_end = 1'b0;
		busy = 1'b0;
		d.erase_go = 1'b0;
		d.prog_go = 1'b0;
		d.ce_p = s_ce;
		d.oe_p = s_oe;
		d.av_p = s_av;
		d.bclk_p = s_bclk;
		d.wr_p = wr;

		// Address follows the pins until address valid rises; data until the end.
		if (wr) begin
			if (!q.got) begin
				if (s_av && !q.av_p) begin
					d.got = 1'b1;
				end else begin
					d.al = s_addr;
				end
			end
			d.dl = s_dq;
		end

		// Write state machine progress; checks run in the first busy cycle.
		case (q.mach)
			fcs_pkg::W_ERASE: begin
				if (q.chk) begin
					d.chk = 1'b0;
					if (!s_vpp) begin
						set_v[`FCS_ST_VLOW] = 1'b1;
						set_v[`FCS_ST_EERR] = 1'b1;
						d.mach = fcs_pkg::W_IDLE;
					end else if (block_locked && !s_wp) begin
						set_v[`FCS_ST_LOCK] = 1'b1;
						set_v[`FCS_ST_EERR] = 1'b1;
						d.mach = fcs_pkg::W_IDLE;
					end else begin
						d.erase_go = 1'b1;
					end
				end else if (q.ecnt == '0) begin
					set_v[`FCS_ST_EERR] = array_fail;
					d.mach = fcs_pkg::W_IDLE;
				end else begin
					d.ecnt = q.ecnt - 1'b1;
				end
			end
			fcs_pkg::W_ESW: begin
				if (q.scnt == '0) begin
					set_v[`FCS_ST_ESUSP] = 1'b1;
					d.mach = fcs_pkg::W_ESUSP;
				end else begin
					d.scnt = q.scnt - 1'b1;
				end
			end
			fcs_pkg::W_PROG: begin
				if (q.chk) begin
					d.chk = 1'b0;
					if (!s_vpp) begin
						set_v[`FCS_ST_VLOW] = 1'b1;
						set_v[`FCS_ST_PERR] = 1'b1;
						prog_end = 1'b1;
					end else if (block_locked && !s_wp) begin
						set_v[`FCS_ST_LOCK] = 1'b1;
						set_v[`FCS_ST_PERR] = 1'b1;
						prog_end = 1'b1;
					end else begin
						d.prog_go = 1'b1;
					end
				end else if (q.pcnt == '0) begin
					set_v[`FCS_ST_PERR] = array_fail;
					prog_end = 1'b1;
				end else begin
					d.pcnt = q.pcnt - 1'b1;
				end
			end
			fcs_pkg::W_PSW: begin
				if (q.scnt == '0) begin
					set_v[`FCS_ST_PSUSP] = 1'b1;
					d.mach = fcs_pkg::W_PSUSP;
				end else begin
					d.scnt = q.scnt - 1'b1;
				end
			end
			default: begin
			end
		endcase

		// A program inside an erase suspend returns there, or resumes a held erase.
		if (prog_end) begin
			d.mach = q.held ? (q.pend ? fcs_pkg::W_ERASE : fcs_pkg::W_ESUSP)
				: fcs_pkg::W_IDLE;
			clr_v[`FCS_ST_ESUSP] = q.held && q.pend;
			d.held = 1'b0;
			d.pend = 1'b0;
		end
		busy = (d.mach != fcs_pkg::W_IDLE) && (d.mach != fcs_pkg::W_ESUSP) &&
			(d.mach != fcs_pkg::W_PSUSP);

		// Command decode at the end of each write cycle.
		if (wr_end) begin
			d.got = 1'b0;
			case (q.ph)
				fcs_pkg::C_ERASE: begin
					d.ph = fcs_pkg::C_CMD;
					d.rm = fcs_pkg::RM_STATUS;
					if (c == `FCS_CMD_CONFIRM) begin
						d.mach = fcs_pkg::W_ERASE;
						d.chk = 1'b1;
						d.ecnt = ERASE_CNT;
						d.op_addr = q.al;
					end else begin
						set_v[`FCS_ST_EERR] = 1'b1;
						set_v[`FCS_ST_PERR] = 1'b1;
					end
				end
				fcs_pkg::C_PROG: begin
					d.ph = fcs_pkg::C_CMD;
					d.rm = fcs_pkg::RM_STATUS;
					d.held = (d.mach == fcs_pkg::W_ESUSP);
					d.mach = fcs_pkg::W_PROG;
					d.chk = 1'b1;
					d.pcnt = PROG_CNT;
					d.op_addr = q.al;
					d.op_data = q.dl;
				end
				fcs_pkg::C_CFG: begin
					d.ph = fcs_pkg::C_CMD;
					d.rm = fcs_pkg::RM_ARRAY;
					if (c == `FCS_CMD_CFG_CONFIRM) begin
						d.rcfg = q.al[`FCS_DATA_W-1:0];
					end
				end
				default: begin
					case (c)
						`FCS_CMD_READ_ARRAY: begin
							if (!busy) begin
								d.rm = fcs_pkg::RM_ARRAY;
							end
						end
						`FCS_CMD_READ_IDENT: begin
							if (d.mach == fcs_pkg::W_IDLE) begin
								d.rm = fcs_pkg::RM_IDENT;
							end
						end
						`FCS_CMD_READ_STATUS: begin
							d.rm = fcs_pkg::RM_STATUS;
						end
						`FCS_CMD_CLEAR_STATUS: begin
							if (d.mach == fcs_pkg::W_IDLE) begin
								clr_v = 8'h3A;
								d.rm = fcs_pkg::RM_ARRAY;
							end
						end
						`FCS_CMD_ERASE_SETUP: begin
							if (d.mach == fcs_pkg::W_IDLE) begin
								d.ph = fcs_pkg::C_ERASE;
							end
						end
						`FCS_CMD_PROG_SETUP, `FCS_CMD_PROG_ALT: begin
							if (d.mach == fcs_pkg::W_IDLE || d.mach == fcs_pkg::W_ESUSP) begin
								d.ph = fcs_pkg::C_PROG;
							end
						end
						`FCS_CMD_CFG_SETUP: begin
							if (d.mach == fcs_pkg::W_IDLE) begin
								d.ph = fcs_pkg::C_CFG;
							end
						end
						`FCS_CMD_SUSPEND: begin
							if (d.mach == fcs_pkg::W_ERASE || d.mach == fcs_pkg::W_PROG) begin
								d.mach = (d.mach == fcs_pkg::W_ERASE) ? fcs_pkg::W_ESW
									: fcs_pkg::W_PSW;
								d.scnt = SUSP_CNT;
								d.rm = fcs_pkg::RM_STATUS;
							end
						end
						`FCS_CMD_CONFIRM: begin
							if (d.mach == fcs_pkg::W_ESUSP) begin
								d.mach = fcs_pkg::W_ERASE;
								clr_v[`FCS_ST_ESUSP] = 1'b1;
								d.rm = fcs_pkg::RM_STATUS;
							end else if (d.mach == fcs_pkg::W_PSUSP) begin
								d.mach = fcs_pkg::W_PROG;
								clr_v[`FCS_ST_PSUSP] = 1'b1;
								d.rm = fcs_pkg::RM_STATUS;
							end else if (d.mach == fcs_pkg::W_PROG && q.held) begin
								d.pend = 1'b1;
								d.rm = fcs_pkg::RM_STATUS;
							end
						end
						default: begin
						end
					endcase
				end
			endcase
		end

		// Sets win over clears; the ready bit follows the machine.
		d.stat = (q.stat & ~clr_v) | set_v;
		d.stat[`FCS_ST_READY] = !busy;
		d.stat[0] = 1'b0;
		// A command that starts or resumes work drops ready in the same cycle.
		if (d.mach != fcs_pkg::W_IDLE && d.mach != fcs_pkg::W_ESUSP &&
			d.mach != fcs_pkg::W_PSUSP) begin
			d.stat[`FCS_ST_READY] = 1'b0;
		end

		// Status snapshot is taken once per read cycle at the first event.
		if (s_oe && s_ce) begin
			d.snap_ok = 1'b0;
		end else if (evt && !q.snap_ok) begin
			d.snap = q.stat;
			d.snap_ok = 1'b1;
		end

		// Output word by read mode; status and identifier are single words.
		d.dq_oe = rd;
		d.arr_addr = s_addr;
		d.single = (q.rm != fcs_pkg::RM_ARRAY);
		case (q.rm)
			fcs_pkg::RM_IDENT: begin
				case (s_addr)
					`FCS_ID_MFR_ADDR: d.dq = MFR_CODE;
					`FCS_ID_DEV_ADDR: d.dq = DEV_CODE;
					`FCS_ID_CFG_ADDR: d.dq = q.rcfg;
					default: d.dq = 16'h0000;
				endcase
			end
			fcs_pkg::RM_STATUS: d.dq = {8'h00, q.snap_ok ? q.snap : q.stat};
			default: d.dq = array_rdata;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register; reset aborts any operation and restores defaults.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.ph <= fcs_pkg::C_CMD;
			q.rm <= fcs_pkg::RM_ARRAY;
			q.mach <= fcs_pkg::W_IDLE;
			q.stat <= `FCS_STATUS_RESET;
			q.rcfg <= `FCS_RCFG_RESET;
			q.ce_p <= 1'b1;
			q.oe_p <= 1'b1;
			q.av_p <= 1'b1;
			q.bclk_p <= 1'b1;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// Outputs come straight from the state register.
	assign dq_out = q.dq;
	assign dq_oe = q.dq_oe;
	assign array_addr = q.arr_addr;
	assign single_word = q.single;
	assign read_config = q.rcfg;
	assign erase_go = q.erase_go;
	assign prog_go = q.prog_go;
	assign op_addr = q.op_addr;
	assign op_data = q.op_data;
	assign operation_status = q.stat;

	////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_busy_not_ready: assert property (
		(q.mach == fcs_pkg::W_ERASE || q.mach == fcs_pkg::W_PROG) |-> !q.stat[7]
	) else $error("ready bit set while busy");

	a_array_ignored: assert property (
		clk_en && wr_end && q.ph == fcs_pkg::C_CMD && c == `FCS_CMD_READ_ARRAY && !q.chk &&
		((q.mach == fcs_pkg::W_PROG && q.pcnt != '0) ||
		(q.mach == fcs_pkg::W_ERASE && q.ecnt != '0))
		|=> q.rm == $past(q.rm)
	) else $error("array read taken while busy");

	a_clear_array: assert property (
		clk_en && wr_end && q.ph == fcs_pkg::C_CMD && c == `FCS_CMD_CLEAR_STATUS &&
		q.mach == fcs_pkg::W_IDLE |=> q.rm == fcs_pkg::RM_ARRAY && q.stat[5:3] == 3'h0
	) else $error("status clear did not clear");

	a_err_sticky: assert property (
		clk_en && q.stat[5] && !(wr_end && c == `FCS_CMD_CLEAR_STATUS)
		|=> q.stat[5]
	) else $error("erase error bit lost");

	a_esusp_flags: assert property (
		q.mach == fcs_pkg::W_ESUSP |-> q.stat[7] && q.stat[6]
	) else $error("erase suspend flags wrong");

	a_psusp_flags: assert property (
		q.mach == fcs_pkg::W_PSUSP |-> q.stat[7] && q.stat[2]
	) else $error("program suspend flags wrong");

	a_lock_abort: assert property (
		clk_en && q.mach == fcs_pkg::W_ERASE && q.chk && s_vpp && block_locked && !s_wp
		|=> q.stat[1] && q.stat[5] && q.mach == fcs_pkg::W_IDLE
	) else $error("locked block not aborted");

	a_vpp_abort: assert property (
		clk_en && q.mach == fcs_pkg::W_PROG && q.chk && !s_vpp |=> q.stat[3] && q.stat[4]
	) else $error("low supply not flagged");

	a_resume_status: assert property (
		clk_en && wr_end && q.ph == fcs_pkg::C_CMD && c == `FCS_CMD_CONFIRM &&
		q.mach == fcs_pkg::W_ESUSP
		|=> q.mach == fcs_pkg::W_ERASE && q.rm == fcs_pkg::RM_STATUS && !q.stat[6]
	) else $error("erase resume wrong");

	a_nested_hold: assert property (
		q.held |-> q.mach != fcs_pkg::W_ERASE && q.mach != fcs_pkg::W_ESW
	) else $error("erase resumed under program");

	a_reset_state: assert property (
		$rose(resetn) |-> q.stat == 8'h80 && q.rm == fcs_pkg::RM_ARRAY
	) else $error("bad state after reset");
endmodule

// *** verif/fcs_host.sv ***
`timescale 1ns/1ps

// Host model: drives the parallel pins just after a rising edge and holds them.
module fcs_host (
	input wire logic clk, // System clock.
	input wire logic [15:0] dq_out, // Read data from the device.
	input wire logic dq_oe, // Device drives the data pins.
	output logic chip_enable_n, // Chip enable.
	output logic write_enable_n, // Write enable.
	output logic output_enable_n, // Output enable.
	output logic address_valid_n, // Address valid.
	output logic [19:0] addr, // Address pins.
	output logic [15:0] dq_in // Data pins towards the device.
);
	// The bus starts idle with every control inactive.
	initial begin
		chip_enable_n = 1'b1;
		write_enable_n = 1'b1;
		output_enable_n = 1'b1;
		address_valid_n = 1'b1;
		addr = 20'h00000;
		dq_in = 16'h0000;
	end

	// One write cycle; released data pins show the inverse of the last word.
	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		dq_in = d;
		chip_enable_n = 1'b0;
		address_valid_n = 1'b0;
		write_enable_n = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		write_enable_n = 1'b1;
		chip_enable_n = 1'b1;
		address_valid_n = 1'b1;
		dq_in = ~d;
		repeat (6) @(posedge clk);
		#1;
	endtask

	// One single-word read, taken while the pins are still asserted.
	task automatic rd(input logic [19:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		chip_enable_n = 1'b0;
		address_valid_n = 1'b0;
		output_enable_n = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		d = (dq_oe === 1'b1) ? dq_out : 16'hXXXX;
		output_enable_n = 1'b1;
		chip_enable_n = 1'b1;
		address_valid_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Polls status until ready, masking the reserved bit.
	task automatic poll(output logic [7:0] st);
		logic [15:0] d;
		st = 8'h00;
		for (int i = 0; i < 30 && st[7] !== 1'b1; i++) begin
			rd(20'h00000, d);
			st = d[7:0] & 8'hFE;
		end
	endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "fcs_map.svh"

module tb;
	localparam logic [15:0] MFR = 16'h0F0F; // Arbitrary value.
	localparam logic [15:0] DEV = 16'h1E2D; // Arbitrary value.
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic write_protect_n = 1'b1;
	logic vpp_ok = 1'b1;
	logic block_locked = 1'b0;
	logic array_fail = 1'b0;
	logic ce_n, we_n, oe_n, av_n, dq_oe, single_word, erase_go, prog_go;
	logic [19:0] addr, array_addr, op_addr;
	logic [15:0] dq_in, dq_out, array_rdata, read_config, op_data;
	logic [7:0] operation_status;
	int err_total = 0;
	int checked = 0;
	int n_erase = 0;
	int n_prog = 0;
	int cyc = 0;

	// The array is a fixed pattern of its address.
	assign array_rdata = array_addr[15:0] ^ 16'h3C3C;

	// Clock of 8 ns.
	always #4 clk = ~clk;

	fcs_host u_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .chip_enable_n(ce_n),
		.write_enable_n(we_n), .output_enable_n(oe_n), .address_valid_n(av_n),
		.addr(addr), .dq_in(dq_in));

	fcs_sequencer #(.ERASE_CYCLES(60), .PROG_CYCLES(40), .SUSPEND_CYCLES(3), .MFR_CODE(MFR),
		.DEV_CODE(DEV)) u_fcs_sequencer (.clk(clk), .resetn(resetn), .clk_en(1'b1),
		.chip_enable_n(ce_n), .write_enable_n(we_n), .output_enable_n(oe_n),
		.address_valid_n(av_n), .burst_clk(1'b0), .write_protect_n(write_protect_n),
		.vpp_ok(vpp_ok), .addr(addr), .dq_in(dq_in), .array_rdata(array_rdata),
		.block_locked(block_locked), .array_fail(array_fail), .dq_out(dq_out),
		.dq_oe(dq_oe), .array_addr(array_addr), .single_word(single_word),
		.read_config(read_config), .erase_go(erase_go), .prog_go(prog_go),
		.op_addr(op_addr), .op_data(op_data), .operation_status(operation_status));

	// Counts start pulses and cycles; a hang ends the run as a mismatch.
	always @(posedge clk) begin
		cyc++;
		if (erase_go === 1'b1) begin
			n_erase++;
		end
		if (prog_go === 1'b1) begin
			n_prog++;
		end
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [19:0] a, input logic [7:0] c);
		u_host.wr(a, {8'h00, c});
	endtask

	task automatic t_reset();
		logic [15:0] d;
		chk({8'h00, operation_status}, 16'h0080);
		chk(read_config, 16'h8000);
		u_host.rd(20'h00123, d);
		chk(d, 16'h0123 ^ 16'h3C3C);
		chk({15'h0000, single_word}, 16'h0000);
	endtask

	task automatic t_ident();
		logic [15:0] d;
		logic [19:0] ia [4];
		logic [15:0] ie [4];
		ia = '{`FCS_ID_MFR_ADDR, `FCS_ID_DEV_ADDR, `FCS_ID_CFG_ADDR, 20'h00002};
		ie = '{MFR, DEV, 16'h8000, 16'h0000};
		cmd(20'h00000, `FCS_CMD_READ_IDENT);
		for (int i = 0; i < 4; i++) begin
			u_host.rd(ia[i], d);
			chk(d, ie[i]);
		end
		chk({15'h0000, single_word}, 16'h0001);
		cmd(20'h00000, `FCS_CMD_READ_ARRAY);
		u_host.rd(20'h00123, d);
		chk(d, 16'h0123 ^ 16'h3C3C);
	endtask

	// Status and clear work with the supply low.
	task automatic t_status();
		logic [15:0] d;
		vpp_ok = 1'b0;
		cmd(20'h00000, `FCS_CMD_READ_STATUS);
		u_host.rd(20'h12345, d);
		chk(d & 16'hFFFE, 16'h0080);
		u_host.rd(20'h00123, d);
		chk(d & 16'hFFFE, 16'h0080);
		cmd(20'h00000, `FCS_CMD_CLEAR_STATUS);
		u_host.rd(20'h00123, d);
		chk(d, 16'h0123 ^ 16'h3C3C);
		vpp_ok = 1'b1;
	endtask

	task automatic t_erase();
		logic [15:0] d;
		logic [7:0] st;
		cmd(20'h00000, `FCS_CMD_ERASE_SETUP);
		cmd(20'h12345, `FCS_CMD_CONFIRM);
		chk(16'(n_erase), 16'h0001);
		chk(op_addr[15:0], 16'h2345);
		u_host.rd(20'h12345, d);
		chk(d & 16'hFF80, 16'h0000);
		cmd(20'h00000, `FCS_CMD_READ_ARRAY);
		u_host.rd(20'h12345, d);
		chk(d & 16'hFF80, 16'h0000);
		u_host.poll(st);
		chk({8'h00, st}, 16'h0080);
	endtask

	task automatic t_suspend();
		logic [15:0] d;
		logic [7:0] st;
		cmd(20'h00000, `FCS_CMD_ERASE_SETUP);
		cmd(20'h20000, `FCS_CMD_CONFIRM);
		cmd(20'h00000, `FCS_CMD_SUSPEND);
		u_host.rd(20'h00000, d);
		chk(d & 16'hFFFE, 16'h00C0);
		cmd(20'h00000, `FCS_CMD_READ_IDENT);
		u_host.rd(20'h00000, d);
		chk(d & 16'hFFFE, 16'h00C0);
		cmd(20'h00000, `FCS_CMD_PROG_SETUP);
		u_host.wr(20'h00077, 16'h5AA5);
		u_host.poll(st);
		chk({8'h00, st}, 16'h00C0);
		cmd(20'h00000, `FCS_CMD_CONFIRM);
		u_host.rd(20'h00000, d);
		chk(d & 16'hFFC0, 16'h0000);
		u_host.poll(st);
		chk({8'h00, st}, 16'h0080);
	endtask

	task automatic t_prog();
		logic [15:0] d;
		logic [7:0] st;
		array_fail = 1'b1;
		cmd(20'h00000, `FCS_CMD_PROG_ALT);
		u_host.wr(20'h00042, 16'hBEEF);
		u_host.poll(st);
		array_fail = 1'b0;
		chk(op_data, 16'hBEEF);
		chk({8'h00, st}, 16'h0090);
		cmd(20'h00000, `FCS_CMD_PROG_SETUP);
		u_host.wr(20'h00043, 16'h1234);
		cmd(20'h00000, `FCS_CMD_SUSPEND);
		u_host.rd(20'h00000, d);
		chk(d & 16'hFFFE, 16'h0094);
		cmd(20'h00000, `FCS_CMD_CONFIRM);
		u_host.poll(st);
		chk(16'(n_prog), 16'h0003);
		chk({8'h00, st}, 16'h0090);
		cmd(20'h00000, `FCS_CMD_CLEAR_STATUS);
		chk({8'h00, operation_status}, 16'h0080);
	endtask

	// Aborted operations: locked block, low supply, broken pairing.
	task automatic t_abort();
		logic [7:0] st;
		write_protect_n = 1'b0;
		block_locked = 1'b1;
		cmd(20'h00000, `FCS_CMD_ERASE_SETUP);
		cmd(20'h30000, `FCS_CMD_CONFIRM);
		u_host.poll(st);
		chk({8'h00, st}, 16'h00A2);
		chk(16'(n_erase), 16'h0002);
		cmd(20'h00000, `FCS_CMD_CLEAR_STATUS);
		write_protect_n = 1'b1;
		block_locked = 1'b0;
		vpp_ok = 1'b0;
		cmd(20'h00000, `FCS_CMD_PROG_SETUP);
		u_host.wr(20'h00005, 16'h0005);
		u_host.poll(st);
		chk({8'h00, st}, 16'h0098);
		vpp_ok = 1'b1;
		cmd(20'h00000, `FCS_CMD_CLEAR_STATUS);
		cmd(20'h00000, `FCS_CMD_ERASE_SETUP);
		cmd(20'h00000, `FCS_CMD_READ_ARRAY);
		u_host.poll(st);
		chk({8'h00, st}, 16'h00B0);
	endtask

	// Reset in the middle of an erase aborts it and restores the defaults.
	task automatic t_reset_abort();
		logic [15:0] d;
		cmd(20'h00000, `FCS_CMD_ERASE_SETUP);
		cmd(20'h40000, `FCS_CMD_CONFIRM);
		resetn = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk({8'h00, operation_status}, 16'h0080);
		u_host.rd(20'h00123, d);
		chk(d, 16'h0123 ^ 16'h3C3C);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Reset for five cycles, then run every scenario in turn.
	initial begin
		repeat (5) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_reset();
		t_ident();
		t_status();
		t_erase();
		t_suspend();
		t_prog();
		t_abort();
		t_reset_abort();
		end_of_test();
	end
endmodule
